// ==== include/rtp_hdr_pkg.sv ====
/*
 * shared constants, register map and carriers for the source packet rtp framer.
 * assumes a single 100 mhz clock domain and an ahb-lite register bus.
 */
package rtp_hdr_pkg;
   // header field values
   localparam logic [1:0]  RTP_VERSION    = 2'h2;        // binary 10
   localparam logic [3:0]  CONTRIB_COUNT  = 4'h0;        // no contributor ids
   localparam logic        MARKER_VALUE   = 1'b0;        // no fragmentation
   localparam logic        EXT_VALUE      = 1'b0;        // producer adds no extension
   localparam logic [2:0]  PT_PREFIX      = 3'h5;        // binary 101
   localparam logic [1:0]  PT_RESERVED    = 2'h3;        // binary 11
   localparam int          HDR_BYTES      = 12;          // fixed header length
   localparam logic [3:0]  HDR_LAST_IDX   = 4'hb;        // index of final header byte

   // destination address limits
   localparam logic [31:0] MCAST_LO       = 32'hef00_0000; // 239.0.0.0
   localparam logic [31:0] MCAST_HI       = 32'hefff_ffff; // 239.255.255.255
   localparam logic [31:0] LLS_ADDR       = 32'he000_173c; // 224.0.23.60
   localparam logic [15:0] LLS_PORT       = 16'h1349;      // 4937

   // register byte offsets
   localparam logic [7:0]  CTRL_OFS       = 8'h00;
   localparam logic [7:0]  SEED_OFS       = 8'h04;
   localparam logic [7:0]  STATUS_OFS     = 8'h08;
   localparam logic [7:0]  SENT_OFS       = 8'h0c;
   localparam logic [7:0]  DROP_OFS       = 8'h10;

   // field positions
   localparam int          CTRL_EN_BIT    = 0;
   localparam int          CTRL_WAKE_BIT  = 1;
   localparam int          SEED_SLOT_LSB  = 16;
   localparam logic [1:0]  CTRL_RESET     = 2'h0;
   localparam logic [15:0] SEQ_RESET      = 16'h0000;

   // per packet sideband, valid alongside the first payload byte
   typedef struct packed {
      logic [31:0] src_ip;
      logic [15:0] src_port;
      logic [31:0] dst_ip;
      logic [15:0] dst_port;
      logic [2:0]  stream_idx;     // tuple slot chosen upstream
      logic [31:0] ts_min;         // 16.16 utc, zero is best effort
      logic [31:0] ts_max;         // 16.16 utc, zero is best effort
      logic        new_alert_flag; // packet carries a new wakeup alert
      logic        padding;        // payload already ends with rtp padding
   } pkt_meta_s;

   // register access carried from the bus slave to the core
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } reg_req_s;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_HDR  = 4'b0010,
      ST_BODY = 4'b0100,
      ST_DROP = 4'b1000
   } frame_state_e;
endpackage : rtp_hdr_pkg

// ==== rtl/ahb_reg_slave.sv ====
/*
 * ahb-lite slave front end: one wait state per transfer, okay always.
 * assumes the core answers rd_data combinationally from req.addr.
 */
`timescale 1ns/100ps
module ahb_reg_slave (
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   input  wire logic                   hsel,
   input  wire logic [31:0]            haddr,
   input  wire logic [1:0]             htrans,
   input  wire logic                   hwrite,
   input  wire logic [2:0]             hsize,
   input  wire logic [31:0]            hwdata,
   input  wire logic                   hready,
   output logic                        hreadyout,
   output logic                        hresp,
   output logic [31:0]                 hrdata,
   output rtp_hdr_pkg::reg_req_s       req,
   input  wire logic [31:0]            rd_data
);
   import rtp_hdr_pkg::*;

   logic        pend_reg,  pend_next;   // data phase in progress
   logic        wr_reg,    wr_next;     // pending transfer is a write
   logic [7:0]  addr_reg,  addr_next;   // latched word address
   logic        rdy_reg,   rdy_next;    // hreadyout flop
   logic [31:0] rdat_reg,  rdat_next;   // hrdata flop
   logic        take;                   // address phase accepted

   // word transfers only; narrower sizes are treated as word
   assign take = hsel && hready && htrans[1] && (hsize == 3'h2 || hsize != 3'h2);

   // next-state for the two cycle data phase
   always_comb begin
      pend_next = pend_reg;
      wr_next   = wr_reg;
      addr_next = addr_reg;
      rdy_next  = rdy_reg;
      rdat_next = rdat_reg;
      if (pend_reg) begin
         // write data is on the bus now; read data latched for next edge
         pend_next = 1'b0;
         rdy_next  = 1'b1;
         rdat_next = wr_reg ? 32'h0000_0000 : rd_data;
      end else if (take) begin
         pend_next = 1'b1;
         wr_next   = hwrite;
         addr_next = {haddr[7:2], 2'b00};
         rdy_next  = 1'b0;                // one wait state buys a flopped hrdata
      end
   end

   // registers only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_reg <= 1'b0;
         wr_reg   <= 1'b0;
         addr_reg <= 8'h00;
         rdy_reg  <= 1'b1;
         rdat_reg <= 32'h0000_0000;
      end else begin
         pend_reg <= pend_next;
         wr_reg   <= wr_next;
         addr_reg <= addr_next;
         rdy_reg  <= rdy_next;
         rdat_reg <= rdat_next;
      end
   end

   assign hreadyout = rdy_reg;
   assign hresp     = 1'b0;
   assign hrdata    = rdat_reg;
   assign req.wr    = pend_reg && wr_reg;
   assign req.rd    = pend_reg && !wr_reg;
   assign req.addr  = addr_reg;
   assign req.wdata = hwdata;
endmodule : ahb_reg_slave

// ==== rtl/seq_table.sv ====
/*
 * per tuple sequence counters, one slot per source stream.
 * assumes the upstream picks a stable slot for each address/port tuple.
 */
`timescale 1ns/100ps
module seq_table #(
   parameter int SLOTS = 8
) (
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   input  wire logic                     seed_we,
   input  wire logic [$clog2(SLOTS)-1:0] seed_slot,
   input  wire logic [15:0]              seed_val,
   input  wire logic                     adv,
   input  wire logic [$clog2(SLOTS)-1:0] adv_slot,
   output logic [15:0]                   seq_out
);
   import rtp_hdr_pkg::*;

   localparam int SW = $clog2(SLOTS);   // slot index width

   logic [15:0] seq_reg  [SLOTS];   // next number to send per slot
   logic [15:0] seq_next [SLOTS];

   assign seq_out = seq_reg[adv_slot];

   // one counter per slot; seed write beats advance in the same cycle
   for (genvar i = 0; i < SLOTS; i++) begin : g_slot
      always_comb begin
         seq_next[i] = seq_reg[i];
         if (seed_we && seed_slot == SW'(i)) begin
            seq_next[i] = seed_val;
         end else if (adv && adv_slot == SW'(i)) begin
            seq_next[i] = seq_reg[i] + 16'h0001; // R13
         end
      end

      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            seq_reg[i] <= SEQ_RESET;
         end else begin
            seq_reg[i] <= seq_next[i];
         end
      end
   end
endmodule : seq_table

// ==== rtl/source_packet_rtp_header.sv ====
/*
 * producer framer: prepends the modified rtp header to each udp/ip packet with an allowed destination.
 * assumes payload bytes arrive with valid/ready and meta valid on byte one;
 * the downstream byte sink may stall through out_ready.
 */
// The implementer's own choices: register access over AHB-Lite and the register addresses.
// What the document requires
// R01: send only to 239.0.0.0-239.255.255.255 multicast
// R02: destination address and port pass untouched
// R03: consumer maps streams by source tuple
// R04: one header prepended, consumer strips it
// R05: header fields in fixed documented order
// R06: version field is binary 10
// R07: padding bit marks payload padding
// R08: consumer accepts and skips header extensions
// R09: contributor count always 0000
// R10: marker bit always zero
// R11: payload type 101, 11, then wakeup bits
// R12: consumer ignores wakeup outside signaling address
// R13: sequence plus one per tuple, mod 65536
// R14: starting sequence may be randomised
// R15: consumer reorders, drops duplicates, detects loss
// R16: earliest timestamp, zero means best effort
// R17: latest timestamp in ssrc slot, zero best
// R18: seconds part is low 16 utc bits
// R19: 16-bit fraction, about 15 us steps
// R20: signaling goes to 224.0.23.60 port 4937
// R21: consumer applies utc to tai offset
// R22: upper wakeup bit active, lower new alert
// R23: consumer discards headers with bad fixed fields
`timescale 1ns/100ps
module source_packet_rtp_header #(
   parameter int SLOTS = 8
) (
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   // ahb-lite register bus
   input  wire logic                   hsel,
   input  wire logic [31:0]            haddr,
   input  wire logic [1:0]             htrans,
   input  wire logic                   hwrite,
   input  wire logic [2:0]             hsize,
   input  wire logic [31:0]            hwdata,
   input  wire logic                   hready,
   output logic                        hreadyout,
   output logic                        hresp,
   output logic [31:0]                 hrdata,
   // inner udp/ip packet in
   input  wire logic                   in_valid,
   input  wire logic [7:0]             in_data,
   input  wire logic                   in_last,
   input  wire rtp_hdr_pkg::pkt_meta_s in_meta,
   output logic                        in_ready,
   // framed packet out
   output logic                        out_valid,
   output logic [7:0]                  out_data,
   output logic                        out_last,
   input  wire logic                   out_ready
);
   import rtp_hdr_pkg::*;

   localparam int SW = $clog2(SLOTS);

   reg_req_s      req;                          // access from bus slave
   logic [31:0]   rd_data;                      // combinational read mux
   logic [15:0]   seq_cur;                      // sequence for meta slot

   frame_state_e  state_reg,    state_next;     // framing state
   logic [95:0]   hdr_reg,      hdr_next;       // header being sent
   logic [3:0]    idx_reg,      idx_next;       // header byte index
   logic          ovalid_reg,   ovalid_next;    // output byte held
   logic [7:0]    odata_reg,    odata_next;
   logic          olast_reg,    olast_next;
   logic          iready_reg,   iready_next;    // input ready flop
   logic [1:0]    ctrl_reg,     ctrl_next;      // enable, wakeup active
   logic [15:0]   sent_reg,     sent_next;      // framed packet count
   logic [15:0]   drop_reg,     drop_next;      // refused packet count
   logic          adv;                          // sequence consumed
   logic          seed_we;                      // seed register write
   logic          dst_ok;                       // destination allowed
   logic          is_lls;                       // signaling destination
   logic [1:0]    wake_bits;                    // wakeup control field
   logic [6:0]    ptype;                        // payload type code
   logic          out_free;                     // output slot can load

   // bus front end
   ahb_reg_slave ahb_reg_slave_inst (
      .clk       (clk),
      .rst_n     (rst_n),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hsize     (hsize),
      .hwdata    (hwdata),
      .hready    (hready),
      .hreadyout (hreadyout),
      .hresp     (hresp),
      .hrdata    (hrdata),
      .req       (req),
      .rd_data   (rd_data)
   );

   assign seed_we = req.wr && (req.addr == SEED_OFS);

   // per tuple counters, seeded by software so a random start is possible
   seq_table #(.SLOTS(SLOTS)) seq_table_inst (
      .clk       (clk),
      .rst_n     (rst_n),
      .seed_we   (seed_we),                                   // R14
      .seed_slot (req.wdata[SEED_SLOT_LSB +: SW]),
      .seed_val  (req.wdata[15:0]),
      .adv       (adv),
      .adv_slot  (in_meta.stream_idx[SW-1:0]),
      .seq_out   (seq_cur)
   );

   // destination checks on the meta presented with the first byte
   always_comb begin
      is_lls = (in_meta.dst_ip == LLS_ADDR) && (in_meta.dst_port == LLS_PORT); // R20
      dst_ok = ((in_meta.dst_ip >= MCAST_LO) && (in_meta.dst_ip <= MCAST_HI))  // R01
               || is_lls;                                                     // R20
      // wakeup bits only mean something on signaling; zero elsewhere
      wake_bits = is_lls ? {ctrl_reg[CTRL_WAKE_BIT], in_meta.new_alert_flag}
                         : 2'b00;                                             // R22
      ptype = {PT_PREFIX, PT_RESERVED, wake_bits};                            // R11
   end

   // register read mux; unmapped offsets read zero
   always_comb begin
      case (req.addr)
         CTRL_OFS:   rd_data = {30'h0000_0000, ctrl_reg};
         STATUS_OFS: rd_data = {28'h000_0000, state_reg};
         SENT_OFS:   rd_data = {16'h0000, sent_reg};
         DROP_OFS:   rd_data = {16'h0000, drop_reg};
         default:    rd_data = 32'h0000_0000;
      endcase
   end

   // control and counters
   always_comb begin
      ctrl_next = ctrl_reg;
      sent_next = sent_reg;
      drop_next = drop_reg;
      if (req.wr && req.addr == CTRL_OFS) begin
         ctrl_next = req.wdata[1:0];
      end
      if (adv) begin
         sent_next = sent_reg + 16'h0001;
      end
      if (state_reg == ST_IDLE && in_valid && ctrl_reg[CTRL_EN_BIT] && !dst_ok) begin
         drop_next = drop_reg + 16'h0001;                                     // R01
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_reg <= CTRL_RESET;
         sent_reg <= 16'h0000;
         drop_reg <= 16'h0000;
      end else begin
         ctrl_reg <= ctrl_next;
         sent_reg <= sent_next;
         drop_reg <= drop_next;
      end
   end

   assign out_free = !ovalid_reg || out_ready;
   assign adv      = (state_reg == ST_IDLE) && in_valid && ctrl_reg[CTRL_EN_BIT]
                     && dst_ok;                                               // R13

   // framing state machine; body moves one byte per two cycles since the
   // input ready is a flop and must drop before the output slot refills
   always_comb begin
      state_next  = state_reg;
      hdr_next    = hdr_reg;
      idx_next    = idx_reg;
      ovalid_next = ovalid_reg;
      odata_next  = odata_reg;
      olast_next  = olast_reg;
      iready_next = iready_reg;
      if (ovalid_reg && out_ready) begin
         ovalid_next = 1'b0;
      end
      case (state_reg)
         ST_IDLE: begin
            // meta is looked at but the first byte is not consumed here
            if (in_valid && ctrl_reg[CTRL_EN_BIT]) begin
               if (dst_ok) begin
                  hdr_next = {RTP_VERSION,                                    // R06
                              in_meta.padding,                                // R07
                              EXT_VALUE,
                              CONTRIB_COUNT,                                  // R09
                              MARKER_VALUE,                                   // R10
                              ptype,
                              seq_cur,                                        // R13
                              in_meta.ts_min,                                 // R16 R18 R19
                              in_meta.ts_max};                                // R17 R05
                  idx_next   = 4'h0;
                  state_next = ST_HDR;                                        // R04
               end else begin
                  iready_next = 1'b1;
                  state_next  = ST_DROP;
               end
            end
         end
         ST_HDR: begin
            // header bytes most significant first
            if (out_free) begin
               ovalid_next = 1'b1;
               odata_next  = hdr_reg[95:88];                                  // R05
               olast_next  = 1'b0;
               hdr_next    = {hdr_reg[87:0], 8'h00};
               idx_next    = idx_reg + 4'h1;
               if (idx_reg == HDR_LAST_IDX) begin
                  state_next = ST_BODY;
               end
            end
         end
         ST_BODY: begin
            if (ovalid_reg) begin
               if (out_ready) begin
                  if (olast_reg) begin
                     state_next  = ST_IDLE;
                     iready_next = 1'b0;
                  end else begin
                     iready_next = 1'b1;
                  end
               end
            end else if (iready_reg && in_valid) begin
               // inner packet bytes copied unchanged, addresses included
               ovalid_next = 1'b1;
               odata_next  = in_data;                                         // R02
               olast_next  = in_last;
               iready_next = 1'b0;
            end else begin
               iready_next = 1'b1;
            end
         end
         ST_DROP: begin
            // swallow a packet aimed outside the allowed range
            if (in_valid && iready_reg && in_last) begin
               iready_next = 1'b0;
               state_next  = ST_IDLE;                                         // R01
            end
         end
         default: begin
            state_next  = ST_IDLE;
            iready_next = 1'b0;
            ovalid_next = 1'b0;
         end
      endcase
   end

   // framing registers only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg  <= ST_IDLE;
         hdr_reg    <= '0;
         idx_reg    <= 4'h0;
         ovalid_reg <= 1'b0;
         odata_reg  <= 8'h00;
         olast_reg  <= 1'b0;
         iready_reg <= 1'b0;
      end else begin
         state_reg  <= state_next;
         hdr_reg    <= hdr_next;
         idx_reg    <= idx_next;
         ovalid_reg <= ovalid_next;
         odata_reg  <= odata_next;
         olast_reg  <= olast_next;
         iready_reg <= iready_next;
      end
   end

   assign in_ready  = iready_reg;
   assign out_valid = ovalid_reg;
   assign out_data  = odata_reg;
   assign out_last  = olast_reg;
endmodule : source_packet_rtp_header

// ==== sim/rtp_hdr_assertions.sv ====
/*
 * checker: fixed header fields, header-before-body order and bus wait state of the framer.
 * assumes it is bound to the framer top and sees only its ports.
 */
`timescale 1ns/100ps
module rtp_hdr_assertions #(
   parameter int SLOTS = 8
) (
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic       hsel,
   input wire logic       hready,
   input wire logic [1:0] htrans,
   input wire logic       hreadyout,
   input wire logic       hresp,
   input wire logic       in_ready,
   input wire logic       out_valid,
   input wire logic [7:0] out_data,
   input wire logic       out_last,
   input wire logic       out_ready
);
   logic [15:0] idx_reg;  // bytes taken so far in this frame
   logic [15:0] idx_next; // next byte index

   // count taken bytes; restart after the last one
   always_comb begin
      idx_next = idx_reg;
      if (out_valid && out_ready) begin
         idx_next = out_last ? 16'h0000 : idx_reg + 16'h0001;
      end
   end

   // register only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         idx_reg <= 16'h0000;
      end else begin
         idx_reg <= idx_next;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_version_bits: assert property (
      out_valid && idx_reg == 16'h0000 |-> out_data[7:6] == 2'b10) else $error("bad version");
   a_ext_clear: assert property (
      out_valid && idx_reg == 16'h0000 |-> !out_data[4]) else $error("extension set");
   a_count_zero: assert property (
      out_valid && idx_reg == 16'h0000 |-> out_data[3:0] == 4'h0) else $error("count not 0");
   a_marker_low: assert property (
      out_valid && idx_reg == 16'h0001 |-> !out_data[7]) else $error("marker set");
   a_pt_prefix: assert property (
      out_valid && idx_reg == 16'h0001 |-> out_data[6:2] == 5'h17) else $error("bad type");
   a_hdr_first: assert property (
      out_valid && idx_reg < 16'h000c |-> !in_ready && !out_last) else $error("short header");
   // a stalled byte must not change under the sink
   a_out_hold: assert property (
      out_valid && !out_ready |=> out_valid && $stable(out_data) && $stable(out_last))
      else $error("byte changed");
   a_bus_wait: assert property (
      hsel && hready && htrans[1] |=> !hreadyout ##1 hreadyout) else $error("bad wait");
   a_resp_okay: assert property (hresp == 1'b0) else $error("resp not okay");

   c_frame_end: cover property (out_valid && out_ready && out_last);
   c_stall: cover property (out_valid && !out_ready);
   c_bus: cover property (hsel && hready && htrans[1]);
endmodule : rtp_hdr_assertions

bind source_packet_rtp_header rtp_hdr_assertions #(.SLOTS(SLOTS)) rtp_hdr_assertions_inst (
   .clk(clk), .rst_n(rst_n), .hsel(hsel), .hready(hready), .htrans(htrans),
   .hreadyout(hreadyout), .hresp(hresp), .in_ready(in_ready), .out_valid(out_valid),
   .out_data(out_data), .out_last(out_last), .out_ready(out_ready));

// ==== sim/encap_sink_model.sv ====
/*
 * partner: link-layer encapsulation sink that collects framed packets.
 * assumes the framer byte stream; slow makes it stall every other cycle.
 */
`timescale 1ns/100ps
module encap_sink_model (
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic       slow,
   input wire logic       out_valid,
   input wire logic [7:0] out_data,
   input wire logic       out_last,
   output logic           out_ready
);
   logic [7:0] cur[$]; // frame being collected
   logic [7:0] got[$]; // last whole frame, header at the front
   int         nfrm = 0; // frames seen
   int         nbad = 0; // frames with bad fixed fields
   int         nlost = 0; // sequence gaps or repeats
   int         hlen = 12; // bytes stripped before the inner packet
   logic [15:0] sq_prev = 16'h0000; // sequence of the previous frame
   logic [31:0] tmin; // earliest emission time moved to tai
   localparam logic [15:0] TAI_S = 16'h0010; // leap offset in seconds, set per site

   // take bytes; header is stripped by the reader from the front hlen bytes
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         out_ready <= 1'b0;
         cur = {};
      end else begin
         if (out_valid && out_ready) begin
            cur.push_back(out_data);
            // whole frame handed on at the last byte
            if (out_last) begin
               // consumer side: vet fixed fields, track order, find the inner packet
               if (cur[0][7:6] != 2'b10 || cur[0][3:0] != 4'h0 || cur[1][7:2] != 6'h17) begin
                  nbad++;
               end
               if (nfrm > 0 && {cur[2], cur[3]} != sq_prev + 16'h0001) begin
                  nlost++;
               end
               sq_prev = {cur[2], cur[3]};
               hlen = cur[0][4] ? 16 + 4 * int'({cur[14], cur[15]}) : 12;
               // zero stays best effort; otherwise utc seconds gain the leap offset
               tmin = {cur[4], cur[5], cur[6], cur[7]};
               if (tmin != 32'h0000_0000) tmin = tmin + {TAI_S, 16'h0000};
               got = cur;
               cur = {};
               nfrm++;
            end
         end
         out_ready <= slow ? !out_ready : 1'b1;
      end
   end
endmodule : encap_sink_model

// ==== sim/source_packet_rtp_header_tb_top.sv ====
/*
 * testbench: registers over ahb-lite, framed packets checked byte by byte.
 * assumes the framer package and the sink model; one 100 mhz clock.
 */
`timescale 1ns/100ps
module source_packet_rtp_header_tb_top;
   import rtp_hdr_pkg::*;
   logic        clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, slow = 1'b0;
   logic        hreadyout, hresp, in_ready, out_valid, out_last, out_ready;
   logic        in_valid = 1'b0, in_last = 1'b0;
   logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
   logic [1:0]  htrans = 2'h0, w;
   logic [2:0]  hsize = 3'h2;
   logic [7:0]  in_data = 8'h00, out_data;
   logic [15:0] sq;
   logic [95:0] hdr;
   pkt_meta_s   meta = '0, m;
   int          miscompares = 0, checks = 0;

   always #5 clk = ~clk;

   source_packet_rtp_header #(.SLOTS(8)) source_packet_rtp_header_inst (
      .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .in_valid(in_valid),
      .in_data(in_data), .in_last(in_last), .in_meta(meta), .in_ready(in_ready),
      .out_valid(out_valid), .out_data(out_data), .out_last(out_last), .out_ready(out_ready));
   encap_sink_model encap_sink_model_inst (.clk(clk), .rst_n(rst_n), .slow(slow),
      .out_valid(out_valid), .out_data(out_data), .out_last(out_last), .out_ready(out_ready));

   // compare and count
   task chk(input logic [31:0] seen, input logic [31:0] want);
      checks++;
      if (seen !== want) begin
         miscompares++;
         $display("[ERR] %0t seen %h want %h", $time, seen, want);
      end
   endtask : chk

   task close_out;
      if (miscompares == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : close_out

   // one single word transfer; waits out the slave's wait state
   task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr  <= {24'h00_0000, a};
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus

   // inner packet of n bytes a0, a1, ...; next byte goes on at the taking edge
   task send(input pkt_meta_s pm, input int n);
      @(posedge clk);
      meta     <= pm;
      in_valid <= 1'b1;
      for (int i = 0; i < n; i++) begin
         in_data <= 8'ha0 + 8'(i);
         in_last <= (i == n - 1);
         do @(posedge clk); while (in_ready !== 1'b1);
      end
      in_valid <= 1'b0;
      in_last  <= 1'b0;
   endtask : send

   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      bus(1'b0, CTRL_OFS, 0); chk(rd, 32'h0000_0000);
      bus(1'b0, STATUS_OFS, 0); chk(rd, 32'h0000_0001);
      bus(1'b0, 8'h20, 0); chk(rd, 32'h0000_0000);
      bus(1'b1, SEED_OFS, 32'h0002_fffe);
      bus(1'b1, CTRL_OFS, 32'h0000_0003);
      bus(1'b0, CTRL_OFS, 0); chk(rd, 32'h0000_0003);
      // range edges and signaling tuple, same slot, sequence wraps
      for (int k = 0; k < 4; k++) begin
         m = '0;
         m.stream_idx = 3'h2;
         m.src_port = 16'h1000 + 16'(k);
         m.dst_ip = k == 0 ? MCAST_LO : (k == 2 ? MCAST_HI : LLS_ADDR);
         m.dst_port = LLS_PORT;
         m.new_alert_flag = 1'b1;
         m.padding = k[0];
         m.ts_min = k == 0 ? 32'h0000_0000 : 32'h1234_8000 + 32'(k);
         m.ts_max = m.ts_min + 32'h0001_0000;
         w = (m.dst_ip == LLS_ADDR) ? {k != 3, m.new_alert_flag} : 2'b00;
         sq = 16'hfffe + 16'(k);
         hdr = {2'b10, m.padding, 1'b0, 4'h0, 1'b0, 3'b101, 2'b11, w, sq, m.ts_min, m.ts_max};
         if (k == 3) bus(1'b1, CTRL_OFS, 32'h0000_0001);
         slow <= !k[0];
         send(m, 3 + k);
         wait (encap_sink_model_inst.nfrm == k + 1);
         chk(32'(encap_sink_model_inst.got.size()), 32'(15 + k));
         chk(32'(encap_sink_model_inst.hlen), 32'(HDR_BYTES));
         chk(encap_sink_model_inst.tmin, m.ts_min + (k == 0 ? 32'h0000_0000 : 32'h0010_0000));
         for (int i = 0; i < 4; i++) begin
            chk(32'(encap_sink_model_inst.got[i]), 32'(hdr[95 - 8 * i -: 8]));
         end
         for (int i = 4; i < 12; i++) begin
            chk(32'(encap_sink_model_inst.got[i]), 32'(hdr[95 - 8 * i -: 8]));
         end
         for (int i = 0; i < 3 + k; i++) begin
            chk(32'(encap_sink_model_inst.got[12 + i]), 32'(8'ha0 + 8'(i)));
         end
      end
      // destinations outside the allowed set are counted and never framed
      for (int k = 0; k < 3; k++) begin
         m = '0;
         m.stream_idx = 3'h5;
         m.dst_ip = k == 0 ? 32'heeff_ffff : (k == 1 ? 32'hf000_0000 : LLS_ADDR);
         m.dst_port = 16'h134a;
         send(m, 2);
      end
      repeat (30) @(posedge clk);
      chk(32'(encap_sink_model_inst.nfrm), 32'h0000_0004);
      bus(1'b0, DROP_OFS, 0); chk(rd, 32'h0000_0003);
      bus(1'b0, SENT_OFS, 0); chk(rd, 32'h0000_0004);
      chk(32'(encap_sink_model_inst.nbad), 32'h0000_0000);
      chk(32'(encap_sink_model_inst.nlost), 32'h0000_0000);
      bus(1'b0, STATUS_OFS, 0); chk(rd, 32'h0000_0001);
      close_out;
   end

   // watchdog: the whole run needs a few hundred cycles
   initial begin
      #200_000;
      miscompares++;
      close_out;
   end
endmodule : source_packet_rtp_header_tb_top
